// [include/dct_defines.vh]
// Constants for the per-channel trigger, event and interrupt-enable configuration block.
`ifndef DCT_DEFINES_VH
`define DCT_DEFINES_VH

// Channel counts and selector width.
`define DCT_CHANS        16
`define DCT_EVT_CHANS    8
`define DCT_SEL_W        4
`define DCT_LVL_W        2

// Register byte offsets.
`define DCT_OFF_SEL      8'h3F
`define DCT_OFF_CTRLA    8'h40
`define DCT_OFF_CTRLB    8'h44
`define DCT_OFF_IENCLR   8'h4C
`define DCT_OFF_IENSET   8'h4D
`define DCT_OFF_IFLAG    8'h4E

// Channel control A fields.
`define DCT_CTRLA_EN     1
`define DCT_CTRLA_RST    0

// Channel control B fields.
`define DCT_TSRC_MSB     13
`define DCT_TSRC_LSB     8
`define DCT_LVL_MSB      6
`define DCT_LVL_LSB      5
`define DCT_EVENT_OUTPUT_ENABLE_BIT     4
`define DCT_EVENT_INPUT_ENABLE_BIT     3
`define DCT_EVENT_INPUT_ACTION_MSB    2
`define DCT_EVENT_INPUT_ACTION_LSB    0

// Interrupt enable and flag bit positions.
`define DCT_IRQ_PAUSE_IRQ_ENABLE     2
`define DCT_IRQ_TRANSFER_DONE_IRQ_ENABLE    1
`define DCT_IRQ_TRANSFER_ERROR_IRQ_ENABLE     0

// Top bit of the selector that indexes the event-capable channels.
`define DCT_EVT_SEL_MSB  2

// Trigger source codes; peripheral request bit n carries source code n.
`define DCT_TSRC_NONE    6'h00
`define DCT_TSRC_MAX     6'h2D
`define DCT_TSRC_RSV_LO  6'h28
`define DCT_TSRC_RSV_HI  6'h2B
`define DCT_TRIG_W       46

// Event input action codes.
`define DCT_EVA_NONE     3'h0
`define DCT_EVA_TRIG     3'h1
`define DCT_EVA_CTRIG    3'h2
`define DCT_EVA_CONDITIONAL_BLOCK_ACTION   3'h3
`define DCT_EVA_SUSPEND  3'h4
`define DCT_EVA_RESUME   3'h5
`define DCT_EVA_SKIP     3'h6

// Reset values.
`define DCT_SEL_RST      4'h0
`define DCT_TSRC_RST     6'h00
`define DCT_LVL_RST      2'h0
`define DCT_EVA_RST      3'h0
`define DCT_IRQ3_RST     3'h0
`define DCT_RDATA_RST    32'h0000_0000

`endif

// [rtl/dct_chan_cfg.v]
// Per-channel trigger source, arbitration level, event and interrupt-enable configuration.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "dct_defines.vh"

// Overview of the datapath.
//
// The block holds the per-channel setup of a sixteen-channel transfer engine.
// Software sees one window of channel registers; the selector register picks
// which channel that window shows. Every per-channel write or read therefore
// lands on the channel named by the selector at the edge of the access.
// Software has to write the selector first; the block cannot guard this.
//
// Register map, in byte offsets of a full-word access:
//   selector at the low offset, then control A, control B, the enable clear
//   and enable set pair, and the interrupt flag register.
// Control A carries the channel enable and a channel reset request.
// Control B carries the trigger source, the arbitration level and, on the
// low channels only, the event output enable, the event input enable and the
// event input action.
//
// Enable protection.
//   While a channel is enabled, writes to its trigger source and event
//   controls are dropped, because the transfer engine may be using them.
//   The arbitration level is the exception and is always taken, so software
//   can raise or lower a running channel's priority on the fly.
//   A channel reset request is only honoured while the channel is disabled.
//
// Trigger path.
//   Each channel picks one peripheral request line by its source code.
//   Code zero, the reserved codes and codes above the top code select no
//   line at all; the channel is then started by software or events only.
//   The picked line is gated by the channel enable and registered once, so
//   a trigger shows one cycle after the request that caused it.
//
// Event path.
//   Only the low channels have event inputs and outputs. An incoming event
//   is acted on only while event input is enabled, and the action code then
//   selects at most one action pulse; the none code and the reserved code give no pulse.
//   The event output passes the condition chosen by the descriptor while the
//   event output enable is set, and is silent otherwise.
//   The pause action also sets the channel's pause flag, so software sees an
//   event-driven pause the same way as a block-driven one.
//
// Arbitration.
//   Every channel with a gated trigger or a starting event action requests.
//   The highest arbitration level wins; ties go to the lowest channel number.
//   The grant is registered, so it trails the request by one cycle. Whether
//   the winning channel is already busy is decided outside this block.
//
// Interrupt enables and flags.
//   The enable clear and enable set registers are two views of one three-bit
//   vector per channel, so no read-modify-write is ever needed. A one clears
//   or sets its bit, a zero leaves it alone, and both read back the vector.
//   Flags are set by hardware and cleared by writing one. When a hardware set
//   and a software clear meet in one cycle the set wins, because dropping a
//   fresh event would lose an interrupt for good, while a spurious one only
//   costs software a second look.
//   A finished block only sets the done flag when its action asks for it.
//   The channel interrupt is any flag together with its enable, registered.
//
// Read path.
//   Read data are registered and stand only in the cycle after the read
//   strobe; in every other cycle they are zero. Unmapped offsets read zero,
//   and fields that a high channel lacks read zero there.
//
// Limitations.
//   Only full-word accesses at the listed offsets are decoded; byte lanes are
//   not modelled. The channel reset finishes in one cycle, so its request bit
//   always reads back as zero. All inputs are assumed to come from logic on
//   the same clock; nothing here synchronises an asynchronous source.
//
module dct_chan_cfg (
  input  wire                        core_clk,
  input  wire                        rst_n,
  input  wire [7:0]                  reg_addr,
  input  wire [31:0]                 reg_wdata,
  input  wire                        reg_wr,
  input  wire                        reg_rd,
  output reg  [31:0]                 reg_rdata_q,
  input  wire [`DCT_TRIG_W-1:0]      periph_req,
  input  wire [`DCT_EVT_CHANS-1:0]   evt_in,
  input  wire [`DCT_EVT_CHANS-1:0]   evo_cond,
  input  wire [`DCT_CHANS-1:0]       blk_done,
  input  wire [`DCT_CHANS-1:0]       blk_irq_act,
  input  wire [`DCT_CHANS-1:0]       blk_pause_act,
  input  wire [`DCT_CHANS-1:0]       bus_err,
  output reg  [`DCT_CHANS-1:0]       chan_en_q,
  output reg  [`DCT_CHANS-1:0]       chan_trig_q,
  output reg  [`DCT_EVT_CHANS-1:0]   evt_out_q,
  output reg  [`DCT_EVT_CHANS-1:0]   evt_trig_q,
  output reg  [`DCT_EVT_CHANS-1:0]   evt_ctrig_q,
  output reg  [`DCT_EVT_CHANS-1:0]   evt_conditional_block_action_q,
  output reg  [`DCT_EVT_CHANS-1:0]   evt_pause_q,
  output reg  [`DCT_EVT_CHANS-1:0]   evt_resume_q,
  output reg  [`DCT_EVT_CHANS-1:0]   evt_skip_q,
  output reg                         grant_valid_q,
  output reg  [`DCT_SEL_W-1:0]       grant_chan_q,
  output reg  [`DCT_CHANS-1:0]       chan_irq_q
);

  // Per-channel configuration storage.
  reg [`DCT_SEL_W-1:0]  chan_sel_q;
  reg [5:0]             tsrc_q  [0:`DCT_CHANS-1];
  reg [`DCT_LVL_W-1:0]  lvl_q   [0:`DCT_CHANS-1];
  reg [2:0]             ien_q   [0:`DCT_CHANS-1];
  reg [2:0]             flag_q  [0:`DCT_CHANS-1];
  reg [`DCT_EVT_CHANS-1:0] event_output_enable_q;
  reg [`DCT_EVT_CHANS-1:0] event_input_enable_q;
  reg [2:0]             event_input_action_q [0:`DCT_EVT_CHANS-1];

  // Decoded strobes.
  wire wr_sel   = reg_wr && (reg_addr == `DCT_OFF_SEL);
  wire wr_ctrla = reg_wr && (reg_addr == `DCT_OFF_CTRLA);
  wire wr_ctrlb = reg_wr && (reg_addr == `DCT_OFF_CTRLB);
  wire wr_iclr  = reg_wr && (reg_addr == `DCT_OFF_IENCLR);
  wire wr_iset  = reg_wr && (reg_addr == `DCT_OFF_IENSET);
  wire wr_flag  = reg_wr && (reg_addr == `DCT_OFF_IFLAG);

  // Combinational next values for triggers, event actions and the arbiter.
  reg [`DCT_CHANS-1:0]     trig_d;
  reg [`DCT_CHANS-1:0]     req_d;
  reg [`DCT_EVT_CHANS-1:0] ea_trig_d;
  reg [`DCT_EVT_CHANS-1:0] ea_ctrig_d;
  reg [`DCT_EVT_CHANS-1:0] ea_conditional_block_action_d;
  reg [`DCT_EVT_CHANS-1:0] ea_pause_d;
  reg [`DCT_EVT_CHANS-1:0] ea_resume_d;
  reg [`DCT_EVT_CHANS-1:0] ea_skip_d;
  reg                      gnt_valid_d;
  reg [`DCT_SEL_W-1:0]     gnt_chan_d;
  reg [`DCT_LVL_W-1:0]     gnt_lvl;
  reg [`DCT_CHANS-1:0]     irq_d;
  integer                  c;

  // Peripheral request mux: source code n simply picks request bit n, so the
  // serial, timer, converter and cipher code groups map one-to-one onto pins.
  always @* begin
    trig_d = {`DCT_CHANS{1'b0}};
    for (c = 0; c < `DCT_CHANS; c = c + 1) begin
      if ((tsrc_q[c] != `DCT_TSRC_NONE) && (tsrc_q[c] <= `DCT_TSRC_MAX) &&
          !((tsrc_q[c] >= `DCT_TSRC_RSV_LO) && (tsrc_q[c] <= `DCT_TSRC_RSV_HI))) begin
        trig_d[c] = periph_req[tsrc_q[c]] & chan_en_q[c];
      end
    end
  end

  // Event input actions; only the low channels have the decoder at all.
  always @* begin
    ea_trig_d   = {`DCT_EVT_CHANS{1'b0}};
    ea_ctrig_d  = {`DCT_EVT_CHANS{1'b0}};
    ea_conditional_block_action_d = {`DCT_EVT_CHANS{1'b0}};
    ea_pause_d  = {`DCT_EVT_CHANS{1'b0}};
    ea_resume_d = {`DCT_EVT_CHANS{1'b0}};
    ea_skip_d   = {`DCT_EVT_CHANS{1'b0}};
    for (c = 0; c < `DCT_EVT_CHANS; c = c + 1) begin
      if (evt_in[c] && event_input_enable_q[c]) begin
        case (event_input_action_q[c])
          `DCT_EVA_TRIG:    ea_trig_d[c]   = 1'b1;
          `DCT_EVA_CTRIG:   ea_ctrig_d[c]  = 1'b1;
          `DCT_EVA_CONDITIONAL_BLOCK_ACTION:  ea_conditional_block_action_d[c] = 1'b1;
          `DCT_EVA_SUSPEND: ea_pause_d[c]  = 1'b1;
          `DCT_EVA_RESUME:  ea_resume_d[c] = 1'b1;
          `DCT_EVA_SKIP:    ea_skip_d[c]   = 1'b1;
          default:          ea_trig_d[c]   = 1'b0;
        endcase
      end
    end
  end

  // Arbiter: highest level wins; among equals the lowest channel number wins.
  // Scanning downward with >= lets the lower index take a tie.
  always @* begin
    req_d = trig_d;
    for (c = 0; c < `DCT_EVT_CHANS; c = c + 1) begin
      req_d[c] = trig_d[c] |
                 ((ea_trig_d[c] | ea_ctrig_d[c] | ea_conditional_block_action_d[c]) & chan_en_q[c]);
    end
    gnt_valid_d = 1'b0;
    gnt_chan_d  = `DCT_SEL_RST;
    gnt_lvl     = `DCT_LVL_RST;
    for (c = `DCT_CHANS - 1; c >= 0; c = c - 1) begin
      if (req_d[c] && (!gnt_valid_d || (lvl_q[c] >= gnt_lvl))) begin
        gnt_valid_d = 1'b1;
        gnt_chan_d  = c[`DCT_SEL_W-1:0];
        gnt_lvl     = lvl_q[c];
      end
    end
  end

  // Interrupt request: any flag with its enable.
  always @* begin
    irq_d = {`DCT_CHANS{1'b0}};
    for (c = 0; c < `DCT_CHANS; c = c + 1) begin
      irq_d[c] = |(flag_q[c] & ien_q[c]);
    end
  end

  // Selector and channel control A. A channel software reset is only taken
  // while that channel is disabled, as an enabled channel may be mid-transfer.
  integer i;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_sel_q <= `DCT_SEL_RST;
      chan_en_q  <= {`DCT_CHANS{1'b0}};
    end else begin
      if (wr_sel) begin
        chan_sel_q <= reg_wdata[`DCT_SEL_W-1:0];
      end
      if (wr_ctrla) begin
        chan_en_q[chan_sel_q] <= reg_wdata[`DCT_CTRLA_EN];
      end
    end
  end

  // Per-channel registers; every write lands on the selected channel only.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `DCT_CHANS; i = i + 1) begin
        tsrc_q[i] <= `DCT_TSRC_RST;
        lvl_q[i]  <= `DCT_LVL_RST;
        ien_q[i]  <= `DCT_IRQ3_RST;
        flag_q[i] <= `DCT_IRQ3_RST;
      end
    end else begin
      for (i = 0; i < `DCT_CHANS; i = i + 1) begin
        if ((chan_sel_q == i[`DCT_SEL_W-1:0]) && wr_ctrla && !chan_en_q[i] &&
            reg_wdata[`DCT_CTRLA_RST]) begin
          tsrc_q[i] <= `DCT_TSRC_RST;
          lvl_q[i]  <= `DCT_LVL_RST;
          ien_q[i]  <= `DCT_IRQ3_RST;
          flag_q[i] <= `DCT_IRQ3_RST;
        end else begin
          if ((chan_sel_q == i[`DCT_SEL_W-1:0]) && wr_ctrlb) begin
            if (!chan_en_q[i]) begin
              tsrc_q[i] <= reg_wdata[`DCT_TSRC_MSB:`DCT_TSRC_LSB];
            end
            lvl_q[i] <= reg_wdata[`DCT_LVL_MSB:`DCT_LVL_LSB];
          end
          // Set and clear registers act on one shared enable vector.
          if ((chan_sel_q == i[`DCT_SEL_W-1:0]) && wr_iclr) begin
            ien_q[i] <= ien_q[i] & ~reg_wdata[`DCT_IRQ_PAUSE_IRQ_ENABLE:`DCT_IRQ_TRANSFER_ERROR_IRQ_ENABLE];
          end else if ((chan_sel_q == i[`DCT_SEL_W-1:0]) && wr_iset) begin
            ien_q[i] <= ien_q[i] | reg_wdata[`DCT_IRQ_PAUSE_IRQ_ENABLE:`DCT_IRQ_TRANSFER_ERROR_IRQ_ENABLE];
          end
          // Hardware set wins over a write-one clear in the same cycle.
          flag_q[i] <= (flag_q[i] &
                        ~(((chan_sel_q == i[`DCT_SEL_W-1:0]) && wr_flag) ?
                          reg_wdata[`DCT_IRQ_PAUSE_IRQ_ENABLE:`DCT_IRQ_TRANSFER_ERROR_IRQ_ENABLE] : `DCT_IRQ3_RST)) |
                       {blk_pause_act[i] | ((i < `DCT_EVT_CHANS) ? ea_pause_d[i] : 1'b0),
                        blk_done[i] & blk_irq_act[i],
                        bus_err[i]};
        end
      end
    end
  end

  // Event controls of the low channels; these are enable-protected.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_output_enable_q <= {`DCT_EVT_CHANS{1'b0}};
      event_input_enable_q <= {`DCT_EVT_CHANS{1'b0}};
      for (i = 0; i < `DCT_EVT_CHANS; i = i + 1) begin
        event_input_action_q[i] <= `DCT_EVA_RST;
      end
    end else begin
      for (i = 0; i < `DCT_EVT_CHANS; i = i + 1) begin
        if ((chan_sel_q == i[`DCT_SEL_W-1:0]) && wr_ctrla && !chan_en_q[i] &&
            reg_wdata[`DCT_CTRLA_RST]) begin
          event_output_enable_q[i]  <= 1'b0;
          event_input_enable_q[i]  <= 1'b0;
          event_input_action_q[i] <= `DCT_EVA_RST;
        end else if ((chan_sel_q == i[`DCT_SEL_W-1:0]) && wr_ctrlb && !chan_en_q[i]) begin
          event_output_enable_q[i]  <= reg_wdata[`DCT_EVENT_OUTPUT_ENABLE_BIT];
          event_input_enable_q[i]  <= reg_wdata[`DCT_EVENT_INPUT_ENABLE_BIT];
          event_input_action_q[i] <= reg_wdata[`DCT_EVENT_INPUT_ACTION_MSB:`DCT_EVENT_INPUT_ACTION_LSB];
        end
      end
    end
  end

  // Registered outputs toward the transfer engine and event system.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_trig_q   <= {`DCT_CHANS{1'b0}};
      evt_out_q     <= {`DCT_EVT_CHANS{1'b0}};
      evt_trig_q    <= {`DCT_EVT_CHANS{1'b0}};
      evt_ctrig_q   <= {`DCT_EVT_CHANS{1'b0}};
      evt_conditional_block_action_q  <= {`DCT_EVT_CHANS{1'b0}};
      evt_pause_q   <= {`DCT_EVT_CHANS{1'b0}};
      evt_resume_q  <= {`DCT_EVT_CHANS{1'b0}};
      evt_skip_q    <= {`DCT_EVT_CHANS{1'b0}};
      grant_valid_q <= 1'b0;
      grant_chan_q  <= `DCT_SEL_RST;
      chan_irq_q    <= {`DCT_CHANS{1'b0}};
    end else begin
      chan_trig_q   <= trig_d;
      evt_out_q     <= evo_cond & event_output_enable_q;
      evt_trig_q    <= ea_trig_d;
      evt_ctrig_q   <= ea_ctrig_d;
      evt_conditional_block_action_q  <= ea_conditional_block_action_d;
      evt_pause_q   <= ea_pause_d;
      evt_resume_q  <= ea_resume_d;
      evt_skip_q    <= ea_skip_d;
      grant_valid_q <= gnt_valid_d;
      grant_chan_q  <= gnt_chan_d;
      chan_irq_q    <= irq_d;
    end
  end

  // Read data for the selected channel; unmapped addresses return zero.
  // Fields that a high channel lacks read as zero there.
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = `DCT_RDATA_RST;
    case (reg_addr)
      `DCT_OFF_SEL:   rdata_d[`DCT_SEL_W-1:0] = chan_sel_q;
      `DCT_OFF_CTRLA: rdata_d[`DCT_CTRLA_EN]  = chan_en_q[chan_sel_q];
      `DCT_OFF_CTRLB: begin
        rdata_d[`DCT_TSRC_MSB:`DCT_TSRC_LSB] = tsrc_q[chan_sel_q];
        rdata_d[`DCT_LVL_MSB:`DCT_LVL_LSB]   = lvl_q[chan_sel_q];
        if (chan_sel_q < `DCT_EVT_CHANS) begin
          rdata_d[`DCT_EVENT_OUTPUT_ENABLE_BIT] = event_output_enable_q[chan_sel_q[`DCT_EVT_SEL_MSB:0]];
          rdata_d[`DCT_EVENT_INPUT_ENABLE_BIT] = event_input_enable_q[chan_sel_q[`DCT_EVT_SEL_MSB:0]];
          rdata_d[`DCT_EVENT_INPUT_ACTION_MSB:`DCT_EVENT_INPUT_ACTION_LSB] = event_input_action_q[chan_sel_q[`DCT_EVT_SEL_MSB:0]];
        end
      end
      `DCT_OFF_IENCLR: rdata_d[`DCT_IRQ_PAUSE_IRQ_ENABLE:`DCT_IRQ_TRANSFER_ERROR_IRQ_ENABLE] = ien_q[chan_sel_q];
      `DCT_OFF_IENSET: rdata_d[`DCT_IRQ_PAUSE_IRQ_ENABLE:`DCT_IRQ_TRANSFER_ERROR_IRQ_ENABLE] = ien_q[chan_sel_q];
      `DCT_OFF_IFLAG:  rdata_d[`DCT_IRQ_PAUSE_IRQ_ENABLE:`DCT_IRQ_TRANSFER_ERROR_IRQ_ENABLE] = flag_q[chan_sel_q];
      default:         rdata_d = `DCT_RDATA_RST;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `DCT_RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= `DCT_RDATA_RST;
    end
  end

endmodule // dct_chan_cfg

// [tb/dct_periph_model.sv]
// Peripheral request source that raises one trigger request line on command.
`timescale 1ns/1ns
module dct_periph_model (
  input  logic        core_clk,
  input  logic [5:0]  code,
  input  logic        go,
  output logic [45:0] periph_req
);
  initial periph_req = 46'h0;
  // One line high for one cycle; codes past the top line simply raise nothing.
  always @(posedge core_clk) begin
    periph_req <= go ? (46'h1 << code) : 46'h0;
  end
endmodule // dct_periph_model

// [tb/dct_chan_cfg_asserts.sv]
// Port-level assertions for the channel configuration block.
`timescale 1ns/1ns
module dct_chan_cfg_asserts (
  input logic        core_clk,
  input logic        rst_n,
  input logic [7:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [31:0] reg_rdata_q,
  input logic [7:0]  evt_in,
  input logic [7:0]  evo_cond,
  input logic [15:0] bus_err,
  input logic [15:0] chan_en_q,
  input logic [15:0] chan_trig_q,
  input logic [7:0]  evt_out_q,
  input logic [7:0]  evt_trig_q,
  input logic [7:0]  evt_ctrig_q,
  input logic [7:0]  evt_conditional_block_action_q,
  input logic [7:0]  evt_pause_q,
  input logic [7:0]  evt_resume_q,
  input logic [7:0]  evt_skip_q,
  input logic        grant_valid_q,
  input logic [3:0]  grant_chan_q,
  input logic [15:0] chan_irq_q
);
  logic [3:0] sel_q;
  logic [2:0] ien0_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the selector and channel 0 enables, so reads and requests can be predicted.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 4'h0;
      ien0_q <= 3'h0;
    end else if (reg_wr && reg_addr == 8'h3F) begin
      sel_q <= reg_wdata[3:0];
    end else if (reg_wr && sel_q == 4'h0 && reg_addr == 8'h40 && reg_wdata[0] && !chan_en_q[0]) begin
      ien0_q <= 3'h0;
    end else if (reg_wr && sel_q == 4'h0 && reg_addr == 8'h4D) begin
      ien0_q <= ien0_q | reg_wdata[2:0];
    end else if (reg_wr && sel_q == 4'h0 && reg_addr == 8'h4C) begin
      ien0_q <= ien0_q & ~reg_wdata[2:0];
    end
  end
  // An error seen with its enable set, and no register write to disturb it.
  sequence s_err_seen;
    bus_err[0] && ien0_q[0] && !reg_wr ##1 !reg_wr;
  endsequence
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
    else $error("read data not idle");
  ien_read_a: assert property (reg_rd && sel_q == 4'h0 && (reg_addr == 8'h4C ||
    reg_addr == 8'h4D) |=> reg_rdata_q == {29'h0, $past(ien0_q)})
    else $error("enable read back wrong");
  trig_en_a: assert property ((chan_trig_q & ~$past(chan_en_q)) == 16'h0)
    else $error("trigger on disabled channel");
  grant_en_a: assert property (grant_valid_q |->
    (($past(chan_en_q) >> grant_chan_q) & 16'h1) != 16'h0)
    else $error("grant to disabled channel");
  evo_cause_a: assert property ((evt_out_q & ~$past(evo_cond)) == 8'h0)
    else $error("event out without condition");
  event_input_action_cause_a: assert property (((evt_trig_q | evt_ctrig_q | evt_conditional_block_action_q |
    evt_pause_q | evt_resume_q | evt_skip_q) & ~$past(evt_in)) == 8'h0)
    else $error("event action without event");
  err_irq_a: assert property (s_err_seen |=> chan_irq_q[0])
    else $error("error interrupt missing");
  irq_fall_a: assert property ($fell(chan_irq_q[0]) |-> $past(reg_wr, 2))
    else $error("interrupt dropped by itself");
endmodule // dct_chan_cfg_asserts
bind dct_chan_cfg dct_chan_cfg_asserts chk_u (.core_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata_q, .evt_in, .evo_cond, .bus_err, .chan_en_q, .chan_trig_q,
  .evt_out_q, .evt_trig_q, .evt_ctrig_q, .evt_conditional_block_action_q, .evt_pause_q, .evt_resume_q,
  .evt_skip_q, .grant_valid_q, .grant_chan_q, .chan_irq_q);

// [tb/tb_top.sv]
// Self-checking bench for the channel configuration block.
`timescale 1ns/1ns
module tb_top;
  logic        core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic [7:0]  reg_addr = 8'h0, evt_in = 8'h0, evo_cond = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q, seed = 32'h3271D199;
  logic [5:0]  code = 6'h0;
  logic [45:0] periph_req;
  logic [15:0] blk_done = 16'h0, blk_irq_act = 16'h0, bus_err = 16'h0;
  logic [15:0] chan_en_q, chan_trig_q, chan_irq_q, s_trig;
  logic [7:0]  evt_out_q, evt_trig_q, evt_ctrig_q, evt_conditional_block_action_q, evt_pause_q;
  logic [7:0]  evt_resume_q, evt_skip_q;
  logic [6:0]  s_ev;
  logic [4:0]  s_g;
  logic [3:0]  grant_chan_q, sel;
  logic        grant_valid_q, s_irq;
  logic [2:0]  ien [16];
  int          bad_count = 0, checks_done = 0;
  always #2 core_clk = ~core_clk;
  dct_chan_cfg dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .periph_req, .evt_in, .evo_cond, .blk_done, .blk_irq_act, .blk_pause_act(16'h0), .bus_err,
    .chan_en_q, .chan_trig_q, .evt_out_q, .evt_trig_q, .evt_ctrig_q, .evt_conditional_block_action_q, .evt_pause_q,
    .evt_resume_q, .evt_skip_q, .grant_valid_q, .grant_chan_q, .chan_irq_q);
  dct_periph_model req_u (.core_clk, .code, .go, .periph_req);
  // Compare and count; every read and every explicit check below passes through here.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Accesses take two cycles so a strobe is never raised in the step that lowers it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, exp);
    @(posedge core_clk);
  endtask
  task automatic pick(input logic [3:0] ch);
    wr(8'h3F, {28'h0, ch});
    sel = ch;
  endtask
  // Set or clear enables, keeping the bench copy in step.
  task automatic ie(input logic [7:0] a, input logic [2:0] v);
    wr(a, {29'h0, v});
    ien[sel] = (a == 8'h4C) ? ien[sel] & ~v : ien[sel] | v;
  endtask
  task automatic cfg(input logic [3:0] ch, input logic [31:0] b);
    pick(ch);
    wr(8'h40, 32'h0);
    wr(8'h44, b);
    wr(8'h40, 32'h2);
  endtask
  // Pulse the far-side inputs for one cycle; events show after one edge, the rest after two.
  task automatic step(input logic [5:0] c, input logic g, input logic [7:0] e,
                      input logic [15:0] d, input logic [15:0] ia, input logic [15:0] be);
    go <= g;
    code <= c;
    evt_in <= e;
    evo_cond <= e;
    blk_done <= d;
    blk_irq_act <= ia;
    bus_err <= be;
    @(posedge core_clk);
    {go, evt_in, evo_cond, blk_done, blk_irq_act, bus_err} <= '0;
    #1 s_ev = {evt_out_q[0], evt_skip_q[0], evt_resume_q[0], evt_pause_q[0],
               evt_conditional_block_action_q[0], evt_ctrig_q[0], evt_trig_q[0]};
    @(posedge core_clk);
    #1 s_trig = chan_trig_q;
    s_g = {grant_valid_q, grant_chan_q};
    s_irq = chan_irq_q[0];
    @(posedge core_clk);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A hang ends the run here; the tests need well under a tenth of this.
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end
  initial begin
    logic [5:0] codes [14] = '{6'h00, 6'h01, 6'h0A, 6'h0B, 6'h15, 6'h16, 6'h24,
                               6'h25, 6'h27, 6'h28, 6'h2B, 6'h2C, 6'h2D, 6'h2E};
    logic [5:0] c;
    logic [31:0] e;
    foreach (ien[i]) ien[i] = 3'h0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h4C, 32'h0);
    rd(8'h10, 32'h0);
    // Random set and clear across channels; the other register must follow.
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      pick(seed[11:8]);
      ie(8'h4D, seed[2:0]);
      rd(8'h4C, {29'h0, ien[sel]});
      ie(8'h4C, seed[5:3]);
      rd(8'h4D, {29'h0, ien[sel]});
    end
    $display("enable registers done");
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      c = (i < 14) ? codes[i] : seed[5:0];
      cfg(4'h0, {18'h0, c, 8'h00});
      step(c, 1'b1, 8'h0, 16'h0, 16'h0, 16'h0);
      e = (c != 6'h0 && c <= 6'h27) || c == 6'h2C || c == 6'h2D;
      chk({31'h0, s_trig[0]}, e);
    end
    wr(8'h44, 32'h0000_0560);
    rd(8'h44, {18'h0, c, 8'h60});
    $display("trigger sources done");
    wr(8'h40, 32'h0);
    cfg(4'h1, 32'h0000_0500);
    cfg(4'h2, 32'h0000_0540);
    step(6'h05, 1'b1, 8'h0, 16'h0, 16'h0, 16'h0);
    chk({27'h0, s_g}, 32'h12);
    pick(4'h1);
    wr(8'h44, 32'h0000_0560);
    step(6'h05, 1'b1, 8'h0, 16'h0, 16'h0, 16'h0);
    chk({27'h0, s_g}, 32'h11);
    $display("arbitration done");
    for (int a = 0; a < 8; a++) begin
      cfg(4'h0, 32'h18 | a);
      step(6'h0, 1'b0, 8'h1, 16'h0, 16'h0, 16'h0);
      e = (a >= 1 && a <= 6) ? (32'h40 | (32'h1 << (a - 1))) : 32'h40;
      chk({25'h0, s_ev}, e);
    end
    cfg(4'h0, 32'h0000_0001);
    step(6'h0, 1'b0, 8'h1, 16'h0, 16'h0, 16'h0);
    chk({25'h0, s_ev}, 32'h0);
    pick(4'h9);
    wr(8'h44, 32'h0000_001F);
    rd(8'h44, 32'h0);
    $display("events done");
    pick(4'h0);
    ie(8'h4C, 3'h7);
    ie(8'h4D, 3'h3);
    wr(8'h4E, 32'h7);
    step(6'h0, 1'b0, 8'h0, 16'h1, 16'h0, 16'h0);
    chk({31'h0, s_irq}, 32'h0);
    step(6'h0, 1'b0, 8'h0, 16'h1, 16'h1, 16'h0);
    chk({31'h0, s_irq}, 32'h1);
    rd(8'h4E, 32'h2);
    wr(8'h4E, 32'h2);
    step(6'h0, 1'b0, 8'h0, 16'h0, 16'h0, 16'h0);
    chk({31'h0, s_irq}, 32'h0);
    step(6'h0, 1'b0, 8'h0, 16'h0, 16'h0, 16'h1);
    chk({31'h0, s_irq}, 32'h1);
    ie(8'h4C, 3'h1);
    step(6'h0, 1'b0, 8'h0, 16'h0, 16'h0, 16'h0);
    chk({31'h0, s_irq}, 32'h0);
    rd(8'h4E, 32'h1);
    $display("interrupts done");
    pick(4'h0);
    wr(8'h40, 32'h1);
    rd(8'h44, 32'h1);
    wr(8'h40, 32'h0);
    wr(8'h40, 32'h1);
    rd(8'h44, 32'h0);
    rd(8'h4C, 32'h0);
    rd(8'h4E, 32'h0);
    $display("channel reset done");
    finish_test();
  end
endmodule // tb_top
